// *** hw/tsi_pkg.sv ***
`default_nettype none
package tsi_pkg;
  // ****************************************
  // memory geometry
  // ****************************************
  localparam int NSTREAM = 16;
  localparam int CH_MAX = 128;
  localparam int IDX_W = 11;
  localparam int WFIFO_DEPTH = 8;
  localparam int WFIFO_W = 27;

  // ****************************************
  // register addresses (low seven address bits)
  // ****************************************
  localparam logic [6:0] ADDR_CTRL = 7'h00;
  localparam logic [6:0] ADDR_MODE = 7'h01;
  localparam logic [6:0] ADDR_ALIGN = 7'h02;
  localparam logic [6:0] ADDR_OFS0 = 7'h03;
  localparam int NUM_OFS = 4;
  localparam int ADDR_SPACE_BIT = 7;

  // ****************************************
  // ctrl_reg fields
  // ****************************************
  localparam int CTRL_STA_LSB = 0;
  localparam int CTRL_MS_BIT = 4;
  localparam int CTRL_MBP_BIT = 5;
  localparam logic [15:0] CTRL_MASK = 16'h003F;
  localparam logic [15:0] CTRL_RST = 16'h0000;

  // ****************************************
  // iface_mode_reg fields
  // ****************************************
  localparam int MODE_DR0_BIT = 0;
  localparam int MODE_DR1_BIT = 1;
  localparam int MODE_SFE_BIT = 2;
  localparam int MODE_OSB_BIT = 3;
  localparam int MODE_GO_BIT = 4;
  localparam int MODE_PAT_LSB = 5;
  localparam logic [15:0] MODE_MASK = 16'h03FF;
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [15:0] ALIGN_RST = 16'h0000;
  localparam logic [15:0] OFS_RST = 16'h0000;

  // ****************************************
  // connection memory word fields
  // ****************************************
  localparam int CM_CH_LSB = 0;
  localparam int CM_ST_LSB = 7;
  localparam int CM_DLY_BIT = 11;
  localparam int CM_OE_BIT = 12;
  localparam int CM_CCO_BIT = 13;
  localparam int CM_PC_BIT = 14;
  localparam int CM_LOOP_BACK_SEL_BIT = 15;
  localparam int CM_PAT_LSB = 11;

  // ****************************************
  // channel timing
  // ****************************************
  localparam logic [6:0] LAST_CH_2M = 7'h1F;
  localparam logic [6:0] LAST_CH_4M = 7'h3F;
  localparam logic [6:0] LAST_CH_8M = 7'h7F;
  localparam int HALF_BIT_DIV = 2;
  localparam logic [7:0] VAR_SAME_FRAME_GAP = 8'h03;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } bus_state_t;
endpackage
`default_nettype wire

// *** hw/wfifo_if.sv ***
`default_nettype none
interface wfifo_if #(parameter int W = 8);
  logic [W-1:0] in_data;
  logic in_valid;
  logic in_ready;
  logic [W-1:0] out_data;
  logic out_valid;
  logic out_ready;
  modport fifo (input in_data, input in_valid, output in_ready,
                output out_data, output out_valid, input out_ready);
  modport user (output in_data, output in_valid, input in_ready,
                input out_data, input out_valid, output out_ready);
endinterface
`default_nettype wire

// *** hw/wfifo.sv ***
`default_nettype none
module wfifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // both sides
  wfifo_if.fifo f
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW-1:0] next_wr_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  assign f.in_ready = (count != (AW+1)'(DEPTH));
  assign f.out_valid = (count != '0);
  assign f.out_data = mem[rd_ptr];

  always_comb
  begin
    push = f.in_valid & f.in_ready;
    pop = f.out_valid & f.out_ready;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push)
      next_wr_ptr = (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + AW'(1);
    if (pop)
      next_rd_ptr = (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + AW'(1);
    if (push & ~pop)
      next_count = count + (AW+1)'(1);
    else if (pop & ~push)
      next_count = count - (AW+1)'(1);
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr] <= f.in_data;
  end
endmodule
`default_nettype wire

// *** hw/tsi_host_port.sv ***
// Operation
// - Bus style select low: separate address and data lines, non-multiplexed timing.
// - Style high: data strobe level at strobe/latch rise picks mode 1 or 2.
// - Multiplexed: address and low byte share lines, upper byte separate, acknowledge returned.
// - Non-multiplexed: 16-bit data, 8-bit address, strobes, acknowledge returned.
// - Everything read/write except data memory and frame alignment register.
// - Top address bit low: low bits pick mode, control, alignment, offset registers.
// - Top address bit high: low seven bits index channels, 32/64/128 by rate.
// - Control register holds block mode, memory select and stream field.
// - Stream field value k steers channel accesses to stream k.
// - Mode register holds pattern, go, standby, evaluation start, rate select.
// - Drive pin low: standby bit enables or disables all serial drivers.
// - Drive pin high: standby ignored, drivers globally enabled.
// - When globally enabled, each channel drives per its output enable bit.
// - Connection-control bit of every location shifted out once per frame.
// - Control bit goes one channel early, interleaved across streams.
// - Processor bit high sends memory word, low sends addressed data byte.
// - Per-channel variable or constant delay from the delay bit.
// - Loopback bit routes transmit stream n channel m into receive same.
// - Rate: zero 2.048, low bit 4.096, high bit 8.192 Mb/s.
// - Variable: output channel n..n+2 next frame, n+3 onward same frame.
// - Constant: data written in frame n read out in frame n+2.
// - Go with block mode loads pattern into top five bits, zeros, self-clears.
`default_nettype none
module tsi_host_port #(
  parameter int HALF_DIV = tsi_pkg::HALF_BIT_DIV
) (
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // host bus control
  input wire logic BUS_STYLE_SELECT,
  input wire logic ADDR_STROBE_LATCH,
  input wire logic DATA_STROBE_READ,
  input wire logic READ_WRITE,
  input wire logic CS_N,
  output logic TRANSFER_ACK_N,
  // host bus address and data
  input wire logic [7:0] ADDR_LINES,
  input wire logic [7:0] MUX_ADDR_DATA_LOW_I,
  output logic [7:0] MUX_ADDR_DATA_LOW_O,
  output logic MUX_ADDR_DATA_LOW_OE,
  input wire logic [7:0] DATA_HIGH_I,
  output logic [7:0] DATA_HIGH_O,
  output logic DATA_HIGH_OE,
  // serial side
  input wire logic OUTPUT_DRIVE_ENABLE_PIN,
  input wire logic [tsi_pkg::NSTREAM-1:0] RX_DATA,
  output logic [tsi_pkg::NSTREAM-1:0] TX_DATA,
  output logic [tsi_pkg::NSTREAM-1:0] TX_OE,
  output logic CONN_CTRL_OUT
);
  // ****************************************
  // storage
  // ****************************************
  logic [15:0] cm [tsi_pkg::NSTREAM*tsi_pkg::CH_MAX];
  logic [7:0] dm [3][tsi_pkg::NSTREAM*tsi_pkg::CH_MAX];

  function automatic logic [1:0] bank_inc(input logic [1:0] b);
    return (b == 2'h2) ? 2'h0 : b + 2'h1;
  endfunction

  function automatic logic [1:0] bank_dec(input logic [1:0] b);
    return (b == 2'h0) ? 2'h2 : b - 2'h1;
  endfunction

  wfifo_if #(.W(tsi_pkg::WFIFO_W)) wf ();

  wfifo #(.W(tsi_pkg::WFIFO_W), .DEPTH(tsi_pkg::WFIFO_DEPTH)) u_wfifo (
    .clk(CLK),
    .nrst(NRST),
    .f(wf.fifo)
  );

  // ****************************************
  // host bus
  // ****************************************
  tsi_pkg::bus_state_t state, next_state;
  logic ale_q, next_ale_q;
  logic [7:0] addr_cap, next_addr_cap;
  logic mux_mode2, next_mux_mode2;
  logic [15:0] ctrl_reg, next_ctrl_reg;
  logic [15:0] iface_mode_reg, next_iface_mode_reg;
  logic [15:0] ofs [tsi_pkg::NUM_OFS];
  logic [15:0] next_ofs [tsi_pkg::NUM_OFS];
  logic [15:0] rdata, next_rdata;
  logic rd_oe, next_rd_oe;
  logic ack_n, next_ack_n;
  logic [7:0] eff_addr;
  logic strobe_act, rd, access;
  logic [15:0] wdata;
  logic [tsi_pkg::IDX_W-1:0] host_idx;
  logic [6:0] ofs_sel;
  logic [1:0] wr_bank;
  logic blk_done;

  always_comb
  begin
    next_state = state;
    next_ale_q = ADDR_STROBE_LATCH;
    next_addr_cap = addr_cap;
    next_mux_mode2 = mux_mode2;
    next_ctrl_reg = ctrl_reg;
    next_iface_mode_reg = iface_mode_reg;
    next_ofs = ofs;
    next_rdata = rdata;
    wf.in_valid = 1'b0;
    if (BUS_STYLE_SELECT & ADDR_STROBE_LATCH & ~ale_q)
    begin
      next_addr_cap = MUX_ADDR_DATA_LOW_I;
      next_mux_mode2 = DATA_STROBE_READ;
    end
    eff_addr = BUS_STYLE_SELECT ? addr_cap : ADDR_LINES;
    if (!BUS_STYLE_SELECT)
    begin
      strobe_act = ~DATA_STROBE_READ;
      rd = READ_WRITE;
    end
    else if (!mux_mode2)
    begin
      strobe_act = ~DATA_STROBE_READ | ~READ_WRITE;
      rd = ~DATA_STROBE_READ;
    end
    else
    begin
      strobe_act = DATA_STROBE_READ;
      rd = READ_WRITE;
    end
    access = ~CS_N & strobe_act;
    wdata = {DATA_HIGH_I, MUX_ADDR_DATA_LOW_I};
    host_idx = {ctrl_reg[tsi_pkg::CTRL_STA_LSB +: 4], eff_addr[6:0]};
    ofs_sel = eff_addr[6:0] - tsi_pkg::ADDR_OFS0;
    wf.in_data = {host_idx, wdata};
    unique case (state)
      tsi_pkg::BUS_IDLE:
      begin
        if (access)
        begin
          if (!eff_addr[tsi_pkg::ADDR_SPACE_BIT])
          begin
            next_state = tsi_pkg::BUS_ACK;
            if (!rd)
            begin
              if (eff_addr[6:0] == tsi_pkg::ADDR_CTRL)
                next_ctrl_reg = wdata & tsi_pkg::CTRL_MASK;
              else if (eff_addr[6:0] == tsi_pkg::ADDR_MODE)
                next_iface_mode_reg = wdata & tsi_pkg::MODE_MASK;
              else if (eff_addr[6:0] >= tsi_pkg::ADDR_OFS0 && ofs_sel < 7'(tsi_pkg::NUM_OFS))
                next_ofs[ofs_sel[1:0]] = wdata;
            end
            else if (eff_addr[6:0] == tsi_pkg::ADDR_CTRL)
              next_rdata = ctrl_reg;
            else if (eff_addr[6:0] == tsi_pkg::ADDR_MODE)
              next_rdata = iface_mode_reg;
            else if (eff_addr[6:0] == tsi_pkg::ADDR_ALIGN)
              next_rdata = tsi_pkg::ALIGN_RST;
            else if (eff_addr[6:0] >= tsi_pkg::ADDR_OFS0 && ofs_sel < 7'(tsi_pkg::NUM_OFS))
              next_rdata = ofs[ofs_sel[1:0]];
            else
              next_rdata = 16'h0000;
          end
          else if (rd)
          begin
            // reads wait until queued writes have landed
            if (!wf.out_valid)
            begin
              next_state = tsi_pkg::BUS_ACK;
              if (ctrl_reg[tsi_pkg::CTRL_MS_BIT])
                next_rdata = {8'h00, dm[bank_dec(wr_bank)][host_idx]};
              else
                next_rdata = cm[host_idx];
            end
          end
          else if (ctrl_reg[tsi_pkg::CTRL_MS_BIT])
            next_state = tsi_pkg::BUS_ACK;
          else
          begin
            wf.in_valid = 1'b1;
            if (wf.in_ready)
              next_state = tsi_pkg::BUS_ACK;
          end
        end
      end
      tsi_pkg::BUS_ACK:
      begin
        if (!access)
          next_state = tsi_pkg::BUS_IDLE;
      end
    endcase
    if (blk_done && !(state == tsi_pkg::BUS_IDLE && next_state == tsi_pkg::BUS_ACK && !rd
        && !eff_addr[tsi_pkg::ADDR_SPACE_BIT] && eff_addr[6:0] == tsi_pkg::ADDR_MODE))
      next_iface_mode_reg[tsi_pkg::MODE_GO_BIT] = 1'b0;
    next_ack_n = (next_state != tsi_pkg::BUS_ACK);
    next_rd_oe = (next_state == tsi_pkg::BUS_ACK) & rd;
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      state <= tsi_pkg::BUS_IDLE;
      ale_q <= 1'b0;
      addr_cap <= 8'h00;
      mux_mode2 <= 1'b0;
      ctrl_reg <= tsi_pkg::CTRL_RST;
      iface_mode_reg <= tsi_pkg::MODE_RST;
      ofs <= '{default: tsi_pkg::OFS_RST};
      rdata <= 16'h0000;
      rd_oe <= 1'b0;
      ack_n <= 1'b1;
    end
    else
    begin
      state <= next_state;
      ale_q <= next_ale_q;
      addr_cap <= next_addr_cap;
      mux_mode2 <= next_mux_mode2;
      ctrl_reg <= next_ctrl_reg;
      iface_mode_reg <= next_iface_mode_reg;
      ofs <= next_ofs;
      rdata <= next_rdata;
      rd_oe <= next_rd_oe;
      ack_n <= next_ack_n;
    end
  end

  assign TRANSFER_ACK_N = ack_n;
  assign MUX_ADDR_DATA_LOW_O = rdata[7:0];
  assign DATA_HIGH_O = rdata[15:8];
  assign MUX_ADDR_DATA_LOW_OE = rd_oe;
  assign DATA_HIGH_OE = rd_oe;

  // ****************************************
  // block programming and memory write port
  // ****************************************
  logic blk_busy;
  logic [tsi_pkg::IDX_W-1:0] blk_idx, next_blk_idx;

  always_comb
  begin
    blk_busy = ctrl_reg[tsi_pkg::CTRL_MBP_BIT] & iface_mode_reg[tsi_pkg::MODE_GO_BIT];
    blk_done = blk_busy & (blk_idx == '1);
    next_blk_idx = blk_busy ? blk_idx + tsi_pkg::IDX_W'(1) : '0;
    wf.out_ready = ~blk_busy;
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      blk_idx <= '0;
    else
      blk_idx <= next_blk_idx;
  end

  always_ff @(posedge CLK)
  begin
    if (blk_busy)
      cm[blk_idx] <= {iface_mode_reg[tsi_pkg::MODE_PAT_LSB +: 5], 11'h000};
    else if (wf.out_valid)
      cm[wf.out_data[26:16]] <= wf.out_data[15:0];
  end

  // ****************************************
  // frame timing
  // ****************************************
  logic [7:0] half_cnt, next_half_cnt;
  logic [3:0] half_idx, next_half_idx;
  logic [6:0] chan, next_chan;
  logic [1:0] next_wr_bank;
  logic [6:0] last_ch, nxt_ch, nxt2_ch;
  logic half_en, bit_en, boundary;
  logic conn_ctrl_out, next_cco;
  logic [tsi_pkg::IDX_W-1:0] cco_idx;
  logic drive_ok;

  always_comb
  begin
    if (iface_mode_reg[tsi_pkg::MODE_DR1_BIT])
      last_ch = tsi_pkg::LAST_CH_8M;
    else if (iface_mode_reg[tsi_pkg::MODE_DR0_BIT])
      last_ch = tsi_pkg::LAST_CH_4M;
    else
      last_ch = tsi_pkg::LAST_CH_2M;
    drive_ok = OUTPUT_DRIVE_ENABLE_PIN | iface_mode_reg[tsi_pkg::MODE_OSB_BIT];
    half_en = (half_cnt == 8'(HALF_DIV - 1));
    bit_en = half_en & half_idx[0];
    boundary = half_en & (half_idx == 4'hF);
    nxt_ch = (chan >= last_ch) ? 7'h00 : chan + 7'h01;
    nxt2_ch = (nxt_ch == last_ch) ? 7'h00 : nxt_ch + 7'h01;
    next_half_cnt = half_en ? 8'h00 : half_cnt + 8'h01;
    next_half_idx = half_en ? half_idx + 4'h1 : half_idx;
    next_chan = boundary ? nxt_ch : chan;
    next_wr_bank = (boundary && nxt_ch == 7'h00) ? bank_inc(wr_bank) : wr_bank;
    // stream k of channel c+1 in half-bit slot k of channel c
    cco_idx = {half_idx + 4'h1, (half_idx == 4'hF) ? nxt2_ch : nxt_ch};
    next_cco = half_en ? cm[cco_idx][tsi_pkg::CM_CCO_BIT] : conn_ctrl_out;
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      half_cnt <= 8'h00;
      half_idx <= 4'h0;
      chan <= 7'h00;
      wr_bank <= 2'h0;
      conn_ctrl_out <= 1'b0;
    end
    else
    begin
      half_cnt <= next_half_cnt;
      half_idx <= next_half_idx;
      chan <= next_chan;
      wr_bank <= next_wr_bank;
      conn_ctrl_out <= next_cco;
    end
  end

  assign CONN_CTRL_OUT = conn_ctrl_out;

  // ****************************************
  // per-stream switching
  // ****************************************
  logic [7:0] rx_byte [tsi_pkg::NSTREAM];

  for (genvar s = 0; s < tsi_pkg::NSTREAM; s++)
  begin : g_stream
    logic [7:0] tx_sr, next_tx_sr;
    logic [7:0] rx_sr, next_rx_sr;
    logic oe, next_oe;
    logic lp, next_lp;
    logic [15:0] cmw;
    logic [1:0] ld_bank, src_bank;
    logic [7:0] tx_byte;
    logic rx_bit;

    always_comb
    begin
      cmw = cm[{4'(s), nxt_ch}];
      ld_bank = (nxt_ch == 7'h00) ? bank_inc(wr_bank) : wr_bank;
      if (cmw[tsi_pkg::CM_DLY_BIT])
        src_bank = bank_inc(ld_bank);
      else if ({1'b0, cmw[tsi_pkg::CM_CH_LSB +: 7]} + tsi_pkg::VAR_SAME_FRAME_GAP <= {1'b0, nxt_ch})
        src_bank = ld_bank;
      else
        src_bank = bank_dec(ld_bank);
      if (cmw[tsi_pkg::CM_PC_BIT])
        tx_byte = cmw[7:0];
      else
        tx_byte = dm[src_bank][{cmw[tsi_pkg::CM_ST_LSB +: 4], cmw[tsi_pkg::CM_CH_LSB +: 7]}];
      rx_bit = lp ? tx_sr[7] : RX_DATA[s];
      rx_byte[s] = {rx_sr[6:0], rx_bit};
      next_tx_sr = tx_sr;
      next_rx_sr = rx_sr;
      next_lp = lp;
      next_oe = drive_ok & oe;
      if (boundary)
      begin
        next_tx_sr = tx_byte;
        next_rx_sr = 8'h00;
        next_lp = cmw[tsi_pkg::CM_LOOP_BACK_SEL_BIT];
        next_oe = drive_ok & cmw[tsi_pkg::CM_OE_BIT];
      end
      else if (bit_en)
      begin
        next_tx_sr = {tx_sr[6:0], 1'b0};
        next_rx_sr = {rx_sr[6:0], rx_bit};
      end
    end

    always_ff @(posedge CLK or negedge NRST)
    begin
      if (!NRST)
      begin
        tx_sr <= 8'h00;
        rx_sr <= 8'h00;
        oe <= 1'b0;
        lp <= 1'b0;
      end
      else
      begin
        tx_sr <= next_tx_sr;
        rx_sr <= next_rx_sr;
        oe <= next_oe;
        lp <= next_lp;
      end
    end

    assign TX_DATA[s] = tx_sr[7];
    assign TX_OE[s] = oe;
  end

  always_ff @(posedge CLK)
  begin
    if (boundary)
    begin
      for (int i = 0; i < tsi_pkg::NSTREAM; i++)
        dm[wr_bank][{4'(i), chan}] <= rx_byte[i];
    end
  end
endmodule
`default_nettype wire

// *** test/tsi_host_port_monitor.sv ***
`default_nettype none
module tsi_host_port_monitor #(
  parameter int HALF_DIV = 2
) (
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // host bus
  input wire logic BUS_STYLE_SELECT,
  input wire logic DATA_STROBE_READ,
  input wire logic READ_WRITE,
  input wire logic CS_N,
  input wire logic TRANSFER_ACK_N,
  input wire logic [7:0] ADDR_LINES,
  input wire logic [7:0] MUX_ADDR_DATA_LOW_O,
  input wire logic MUX_ADDR_DATA_LOW_OE,
  input wire logic DATA_HIGH_OE,
  // serial side
  input wire logic CONN_CTRL_OUT
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);
  // ****************************************
  // handshake
  // ****************************************
  AST_ACK_RELEASE: assert property (!TRANSFER_ACK_N && CS_N |=> TRANSFER_ACK_N)
    else $error("ack held after chip select release");
  AST_ACK_NEEDS_CS: assert property (!TRANSFER_ACK_N |-> $past(!CS_N))
    else $error("ack without chip select");
  AST_REG_ACK_ONE: assert property (!BUS_STYLE_SELECT && !CS_N && !DATA_STROBE_READ && !ADDR_LINES[7]
    && TRANSFER_ACK_N && $past(TRANSFER_ACK_N) |=> !TRANSFER_ACK_N)
    else $error("register access not answered in one cycle");
  // ****************************************
  // read data drive, control bit hold, cover points
  // ****************************************
  AST_OE_PAIR: assert property (MUX_ADDR_DATA_LOW_OE == DATA_HIGH_OE)
    else $error("byte lanes driven apart");
  AST_OE_WITH_ACK: assert property (MUX_ADDR_DATA_LOW_OE |-> !TRANSFER_ACK_N)
    else $error("data driven without ack");
  AST_OE_READ_ONLY: assert property ($rose(MUX_ADDR_DATA_LOW_OE) && !BUS_STYLE_SELECT |-> $past(READ_WRITE))
    else $error("data driven on a write");
  AST_DATA_STANDS: assert property (MUX_ADDR_DATA_LOW_OE && $past(MUX_ADDR_DATA_LOW_OE)
    |-> $stable(MUX_ADDR_DATA_LOW_O))
    else $error("read data changed while driven");
  AST_CCO_HOLD: assert property (HALF_DIV > 1 && $changed(CONN_CTRL_OUT) |=> $stable(CONN_CTRL_OUT))
    else $error("control bit shorter than a slot");
  COV_MUX_READ: cover property (BUS_STYLE_SELECT && $rose(MUX_ADDR_DATA_LOW_OE));
  COV_NONMUX_WRITE: cover property (!BUS_STYLE_SELECT && !READ_WRITE && $fell(TRANSFER_ACK_N));
  COV_CCO_HIGH: cover property (CONN_CTRL_OUT [*8]);
endmodule
bind tsi_host_port tsi_host_port_monitor #(.HALF_DIV(HALF_DIV)) mon (.CLK, .NRST, .BUS_STYLE_SELECT,
  .DATA_STROBE_READ, .READ_WRITE, .CS_N, .TRANSFER_ACK_N, .ADDR_LINES, .MUX_ADDR_DATA_LOW_O,
  .MUX_ADDR_DATA_LOW_OE, .DATA_HIGH_OE, .CONN_CTRL_OUT);
`default_nettype wire

// *** test/tsi_host_model.sv ***
`default_nettype none
module tsi_host_model (
  // clock and answer
  input wire logic clk,
  input wire logic ack_n,
  input wire logic [7:0] lo_in,
  input wire logic [7:0] hi_in,
  // bus pins
  output var logic style,
  output var logic ale,
  output var logic dsr,
  output var logic rw,
  output var logic cs_n,
  output var logic [7:0] addr,
  output var logic [7:0] lo,
  output var logic [7:0] hi
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    style = 1'b0;
    ale = 1'b0;
    dsr = 1'b1;
    rw = 1'b1;
    cs_n = 1'b1;
    addr = 8'h00;
    lo = 8'h00;
    hi = 8'h00;
  end
  // m: 0 separate lines, 1 mux mode 1, 2 mux mode 2
  task automatic acc(input int m, input logic [7:0] a, input logic rd, input logic [15:0] wd,
                     output logic [15:0] q);
    int n;
    @(negedge clk);
    style = (m != 0);
    addr = (m != 0) ? ~a : a;
    if (m != 0)
    begin
      dsr = (m == 2);
      lo = a;
      ale = 1'b1;
      @(negedge clk);
      ale = 1'b0;
      @(negedge clk);
    end
    lo = rd ? ~lo : wd[7:0];
    hi = rd ? ~hi : wd[15:8];
    rw = rd;
    dsr = (m == 0) ? 1'b0 : (m == 2) ? 1'b1 : !rd;
    cs_n = 1'b0;
    n = 0;
    while (ack_n !== 1'b0 && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    q = {hi_in, lo_in};
    @(negedge clk);
    cs_n = 1'b1;
    dsr = (m != 2);
    rw = 1'b1;
    lo = ~lo;
    hi = ~hi;
    n = 0;
    while (ack_n !== 1'b1 && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
  endtask
endmodule
`default_nettype wire

// *** test/tsi_host_port_tb.sv ***
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("[FAIL] %0t got %h exp %h", $time, got, exp); end end
module tsi_host_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic output_drive_enable_pin = 1'b0;
  logic style, ale, dsr, rw, cs_n, ack_n, lo_oe, hi_oe, conn_ctrl_out;
  logic [7:0] addr, h_lo, h_hi, lo_o, hi_o, lo_w, hi_w;
  logic [15:0] tx, tx_oe;
  int n_mismatch = 0;
  int total_checks = 0;
  always #25 clk = ~clk;
  assign lo_w = lo_oe ? lo_o : h_lo;
  assign hi_w = hi_oe ? hi_o : h_hi;
  tsi_host_port #(.HALF_DIV(2)) DUT (.CLK(clk), .NRST(nrst), .BUS_STYLE_SELECT(style),
    .ADDR_STROBE_LATCH(ale), .DATA_STROBE_READ(dsr), .READ_WRITE(rw), .CS_N(cs_n),
    .TRANSFER_ACK_N(ack_n), .ADDR_LINES(addr), .MUX_ADDR_DATA_LOW_I(lo_w), .MUX_ADDR_DATA_LOW_O(lo_o),
    .MUX_ADDR_DATA_LOW_OE(lo_oe), .DATA_HIGH_I(hi_w), .DATA_HIGH_O(hi_o), .DATA_HIGH_OE(hi_oe),
    .OUTPUT_DRIVE_ENABLE_PIN(output_drive_enable_pin), .RX_DATA(~tx), .TX_DATA(tx), .TX_OE(tx_oe), .CONN_CTRL_OUT(conn_ctrl_out));
  tsi_host_model H (.clk(clk), .ack_n(ack_n), .lo_in(lo_w), .hi_in(hi_w), .style(style), .ale(ale),
    .dsr(dsr), .rw(rw), .cs_n(cs_n), .addr(addr), .lo(h_lo), .hi(h_hi));
  // ****************************************
  // bus helpers
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] q;
    H.acc(0, a, 1'b0, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] q);
    H.acc(0, a, 1'b1, 16'h0000, q);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
    begin
      $display("== PASSED ==");
    end
    else
    begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    `CHK(ack_n, 1'b1)
    `CHK({lo_oe, hi_oe}, 2'b00)
    `CHK(tx_oe, 16'h0000)
    `CHK(conn_ctrl_out, 1'b0)
    $display("test reset done");
  endtask
  task automatic t_regs();
    logic [15:0] q;
    logic [15:0] wv [3] = '{16'hFFFF, 16'h002A, 16'h0015};
    for (int m = 0; m < 3; m++)
    begin
      H.acc(m, 8'h00, 1'b0, wv[m], q);
      H.acc(m, 8'h00, 1'b1, 16'h0000, q);
      `CHK(q, wv[m] & tsi_pkg::CTRL_MASK)
    end
    wr(8'h01, 16'h03E7);
    rd(8'h01, q);
    `CHK(q, 16'h03E7)
    wr(8'h02, 16'hFFFF);
    rd(8'h02, q);
    `CHK(q, 16'h0000)
    wr(8'h10, 16'hFFFF);
    rd(8'h10, q);
    `CHK(q, 16'h0000)
    for (int i = 0; i < 4; i++)
      wr(8'h03 + 8'(i), 16'h0000);
    wr(8'h01, 16'h0000);
    $display("test registers done");
  endtask
  task automatic t_chan();
    logic [15:0] q;
    wr(8'h00, 16'h0003);
    wr(8'h85, 16'h1234);
    wr(8'h00, 16'h0004);
    wr(8'h85, 16'h5678);
    wr(8'h00, 16'h0003);
    rd(8'h85, q);
    `CHK(q, 16'h1234)
    wr(8'h00, 16'h0004);
    rd(8'h85, q);
    `CHK(q, 16'h5678)
    $display("test channel space done");
  endtask
  task automatic t_block();
    logic [15:0] q;
    wr(8'h00, 16'h0020);
    wr(8'h01, 16'h00D0);
    repeat (2100) @(negedge clk);
    rd(8'h01, q);
    `CHK(q, 16'h00C0)
    wr(8'h00, 16'h0003);
    rd(8'h80, q);
    `CHK(q, 16'h3000)
    `CHK(tx_oe, 16'h0000)
    for (int i = 0; i < 64; i++)
    begin
      @(negedge clk);
      `CHK(conn_ctrl_out, 1'b1)
    end
    output_drive_enable_pin = 1'b1;
    repeat (80) @(negedge clk);
    `CHK(tx_oe, 16'hFFFF)
    output_drive_enable_pin = 1'b0;
    wr(8'h01, 16'h00C8);
    repeat (80) @(negedge clk);
    `CHK(tx_oe, 16'hFFFF)
    wr(8'h00, 16'h0020);
    wr(8'h01, 16'h0018);
    repeat (2200) @(negedge clk);
    `CHK(tx_oe, 16'h0000)
    `CHK(conn_ctrl_out, 1'b0)
    $display("test block program and drive done");
  endtask
  task automatic t_loop();
    logic [15:0] q;
    int ones;
    wr(8'h00, 16'h0020);
    wr(8'h01, 16'h0110);
    repeat (2100) @(negedge clk);
    wr(8'h00, 16'h0000);
    wr(8'h82, 16'hC0A5);
    wr(8'h83, 16'h40A5);
    wr(8'h85, 16'h0803);
    repeat (4200) @(negedge clk);
    ones = 0;
    repeat (1024)
    begin
      @(negedge clk);
      if (tx[0] === 1'b1)
        ones++;
    end
    `CHK(ones, 48)
    wr(8'h00, 16'h0010);
    rd(8'h82, q);
    `CHK(q, 16'h00A5)
    H.acc(2, 8'h83, 1'b1, 16'h0000, q);
    `CHK(q, 16'h005A)
    rd(8'h85, q);
    `CHK(q, 16'h00A5)
    $display("test loopback and switching done");
  endtask
  initial
  begin
    #1500000;
    n_mismatch++;
    tally_and_finish();
  end
  initial
  begin
    repeat (2) @(negedge clk);
    t_reset();
    @(negedge clk);
    nrst = 1'b1;
    t_regs();
    t_chan();
    t_block();
    t_loop();
    tally_and_finish();
  end
endmodule
`default_nettype wire
